// file: src/adcm_ctrl.sv
// ADC input configuration, input phase and soft-mute control with
// per-channel S-curve attenuation of the output sample data.
// Assumes the serial control port is decoded outside into a byte
// register port, and that sample_en pulses once per sample frame.
`timescale 1ns/1ps
`default_nettype none
module adcm_ctrl
	import adcm_pkg::*;
(
	// Clock and reset
	input  wire logic                           mclk,
	input  wire logic                           rst_b,
	// Register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [7:0]                     reg_rdata,
	// Settings held in neighbouring registers
	input  wire logic                           attenuation_ramp_speed,
	input  wire logic [ADCM_CH_N*ADCM_GAIN_W-1:0] atten_level,
	// Analog front-end selects
	output logic      [ADCM_CH_N-1:0]           single_ended_select,
	output logic      [ADCM_CH_N-1:0]           input_invert_select,
	// Sample data path
	input  wire logic                           sample_en,
	input  wire logic [ADCM_CH_N*ADCM_DATA_W-1:0] sample_in,
	output logic      [ADCM_CH_N*ADCM_DATA_W-1:0] sample_out
);
	// Unsigned 8x8 gain product, kept to 8 bits
	function automatic logic [ADCM_GAIN_W-1:0] gain_mul(
		input logic [ADCM_GAIN_W-1:0] a,
		input logic [ADCM_GAIN_W-1:0] b);
		logic [15:0] p;
		p = a * b;
		return p[15:8];
	endfunction

	// Signed sample times unsigned gain, back to sample width
	function automatic logic [ADCM_DATA_W-1:0] gain_apply(
		input logic [ADCM_DATA_W-1:0] s,
		input logic [ADCM_GAIN_W-1:0] g);
		logic signed [ADCM_DATA_W+ADCM_GAIN_W:0] p;
		p = $signed(s) * $signed({1'b0, g});
		return p[ADCM_DATA_W+ADCM_GAIN_W-1:ADCM_GAIN_W];
	endfunction

	// Register state
	logic [ADCM_CH_N-1:0]   cfg_reg, cfg_next;     // Single-ended selects
	logic [ADCM_CH_N-1:0]   phase_reg, phase_next; // Input invert selects
	logic [ADCM_CH_N-1:0]   mute_reg, mute_next;   // Soft-mute enables
	logic [7:0]             rdata_reg, rdata_next; // Read data

	// Ramp state
	logic [1:0]             div_reg, div_next;     // Samples since last step
	logic                   step_en;               // One ramp step this frame
	logic [ADCM_POS_W-1:0]  pos_reg [ADCM_CH_N];   // Ramp position per channel
	logic [ADCM_POS_W-1:0]  pos_next [ADCM_CH_N];
	logic [ADCM_GAIN_W-1:0] frac [ADCM_CH_N];      // S-curve fraction
	logic [ADCM_CH_N*ADCM_DATA_W-1:0] out_reg, out_next;

	// Register writes and reads
	always_comb begin
		cfg_next   = cfg_reg;
		phase_next = phase_reg;
		mute_next  = mute_reg;
		rdata_next = rdata_reg;
		if (reg_wr) begin
			unique case (reg_addr)
				ADCM_OFS_CFG: begin
					cfg_next = reg_wdata[ADCM_FLD_MSB:ADCM_FLD_LSB];
				end
				ADCM_OFS_PHASE: begin
					phase_next = reg_wdata[ADCM_FLD_MSB:ADCM_FLD_LSB];
				end
				ADCM_OFS_MUTE: begin
					mute_next = reg_wdata[ADCM_FLD_MSB:ADCM_FLD_LSB];
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				ADCM_OFS_CFG:   rdata_next = {2'h0, cfg_reg};
				ADCM_OFS_PHASE: rdata_next = {2'h0, phase_reg};
				ADCM_OFS_MUTE:  rdata_next = {2'h0, mute_reg};
				default:        rdata_next = ADCM_RD_NONE;
			endcase
		end
	end

	// Register flops
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cfg_reg   <= ADCM_RST_CFG;
			phase_reg <= ADCM_RST_PHASE;
			mute_reg  <= ADCM_RST_MUTE;
			rdata_reg <= ADCM_RD_NONE;
		end else begin
			cfg_reg   <= cfg_next;
			phase_reg <= phase_next;
			mute_reg  <= mute_next;
			rdata_reg <= rdata_next;
		end
	end

	// Front-end selects follow the registers directly
	assign single_ended_select = cfg_reg;
	assign input_invert_select = phase_reg;
	assign reg_rdata           = rdata_reg;

	// Ramp step divider; slow speed stretches each step over frames
	always_comb begin
		logic [1:0] lim;
		lim      = attenuation_ramp_speed ? ADCM_DIV_SLOW : ADCM_DIV_FAST;
		div_next = div_reg;
		step_en  = 1'b0;
		if (sample_en) begin
			if (div_reg >= lim) begin
				div_next = 2'h0;
				step_en  = 1'b1;
			end else begin
				div_next = div_reg + 2'h1;
			end
		end
	end

	// Per-channel ramp position and gain
	always_comb begin
		logic [ADCM_GAIN_W-1:0] lvl;
		logic [ADCM_GAIN_W-1:0] eff;
		lvl      = '0;
		eff      = '0;
		out_next = out_reg;
		for (int c = 0; c < ADCM_CH_N; c++) begin
			pos_next[c] = pos_reg[c];
			if (step_en) begin
				if (mute_reg[c] && pos_reg[c] != ADCM_POS_MIN) begin
					pos_next[c] = pos_reg[c] - 6'h01;
				end else if (!mute_reg[c] && pos_reg[c] != ADCM_POS_MAX) begin
					pos_next[c] = pos_reg[c] + 6'h01;
				end
			end
			if (sample_en) begin
				lvl = atten_level[c*ADCM_GAIN_W +: ADCM_GAIN_W];
				// mute curve scales the one attenuator gain
				eff = gain_mul(lvl, frac[c]);
				// settled and unmuted, use the level as is
				if (pos_reg[c] == ADCM_POS_MAX && !mute_reg[c]) begin
					eff = lvl;
				end
				if (pos_reg[c] == ADCM_POS_MIN) begin
					eff = '0;
				end
				out_next[c*ADCM_DATA_W +: ADCM_DATA_W] = gain_apply(
					sample_in[c*ADCM_DATA_W +: ADCM_DATA_W], eff);
			end
		end
	end

	// Ramp and data flops; ramps start settled at the programmed level
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			div_reg <= 2'h0;
			out_reg <= '0;
			for (int c = 0; c < ADCM_CH_N; c++) begin
				pos_reg[c] <= ADCM_POS_MAX;
			end
		end else begin
			div_reg <= div_next;
			out_reg <= out_next;
			for (int c = 0; c < ADCM_CH_N; c++) begin
				pos_reg[c] <= pos_next[c];
			end
		end
	end

	assign sample_out = out_reg;

	// One table per channel; the one-clock latency is far below a frame
	for (genvar g = 0; g < ADCM_CH_N; g++) begin : g_rom
		adcm_scurve_rom u_rom (
			.mclk (mclk),
			.pos  (pos_reg[g]),
			.frac (frac[g])
		);
	end
endmodule
`default_nettype wire

// file: common/adcm_pkg.sv
// Constants for the ADC input and soft-mute control block.
// Assumes a single 125 MHz clock and a one-cycle sample strobe per frame.
package adcm_pkg;
	// Channel count and widths
	localparam int          ADCM_CH_N      = 6;
	localparam int          ADCM_DATA_W    = 24;
	localparam int          ADCM_GAIN_W    = 8;
	localparam int          ADCM_POS_W     = 6;
	// Register offsets on the control port
	localparam logic [7:0]  ADCM_OFS_CFG   = 8'h53;
	localparam logic [7:0]  ADCM_OFS_PHASE = 8'h54;
	localparam logic [7:0]  ADCM_OFS_MUTE  = 8'h55;
	// Reset values of the three registers
	localparam logic [5:0]  ADCM_RST_CFG   = 6'h00;
	localparam logic [5:0]  ADCM_RST_PHASE = 6'h00;
	localparam logic [5:0]  ADCM_RST_MUTE  = 6'h00;
	// Live field: bits 5..0, one per channel
	localparam int          ADCM_FLD_LSB   = 0;
	localparam int          ADCM_FLD_MSB   = 5;
	// Ramp end points of the S-curve position
	localparam logic [5:0]  ADCM_POS_MIN   = 6'h00;
	localparam logic [5:0]  ADCM_POS_MAX   = 6'h3f;
	// Divider limit per speed setting; one ramp step every limit+1 samples
	localparam logic [1:0]  ADCM_DIV_FAST  = 2'h0;
	localparam logic [1:0]  ADCM_DIV_SLOW  = 2'h3;
	// Read value of an unmapped address
	localparam logic [7:0]  ADCM_RD_NONE   = 8'h00;
endpackage

// file: src/adcm_scurve_rom.sv
// S-curve gain table: ramp position in, gain fraction out.
// Assumes the caller tolerates one clock of read latency.
`timescale 1ns/1ps
`default_nettype none
module adcm_scurve_rom
	import adcm_pkg::*;
(
	// Clock
	input  wire logic                   mclk,
	// Lookup
	input  wire logic [ADCM_POS_W-1:0]  pos,
	output logic      [ADCM_GAIN_W-1:0] frac
);
	// Smoothstep 3x^2 - 2x^3 scaled to 0..255 over 0..63
	function automatic logic [ADCM_GAIN_W-1:0] smooth(input logic [5:0] p);
		int unsigned x;
		int unsigned num;
		x   = 32'(p);
		num = 255 * (3 * x * x * 63 - 2 * x * x * x);
		return ADCM_GAIN_W'(num / 250047);
	endfunction

	logic [ADCM_GAIN_W-1:0] frac_next; // Table value for current address

	// Table lookup
	always_comb begin
		frac_next = smooth(pos);
	end

	// Registered read data
	always_ff @(posedge mclk) begin
		frac <= frac_next;
	end
endmodule
`default_nettype wire

// file: tb/adcm_ctrl_properties.sv
// Port checker for adcm_ctrl: register port and sample hold.
// Bound to every adcm_ctrl; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adcm_ctrl_props
	import adcm_pkg::*;
(
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  rst_b,
	// Register port
	input wire logic [7:0]            reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [7:0]            reg_rdata,
	// Selects and samples
	input wire logic [ADCM_CH_N-1:0]  single_ended_select,
	input wire logic [ADCM_CH_N-1:0]  input_invert_select,
	input wire logic                  sample_en,
	input wire logic [143:0]          sample_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_cfg_write:
	assert property (reg_wr && reg_addr == ADCM_OFS_CFG |=>
		single_ended_select == $past(reg_wdata[5:0])) else $error("cfg");
	a_phase_write:
	assert property (reg_wr && reg_addr == ADCM_OFS_PHASE |=>
		input_invert_select == $past(reg_wdata[5:0])) else $error("phase");
	a_sel_hold:
	assert property (!reg_wr |=> $stable(single_ended_select)
		&& $stable(input_invert_select)) else $error("sel hold");
	a_rd_cfg:
	assert property (reg_rd && reg_addr == ADCM_OFS_CFG |=>
		reg_rdata == {2'h0, $past(single_ended_select)}) else $error("rd");
	a_rd_phase:
	assert property (reg_rd && reg_addr == ADCM_OFS_PHASE |=>
		reg_rdata == {2'h0, $past(input_invert_select)}) else $error("rd");
	a_rd_none:
	assert property (reg_rd && !(reg_addr inside {[8'h53:8'h55]}) |=>
		reg_rdata == ADCM_RD_NONE) else $error("unmapped");
	a_rd_mute:
	assert property (reg_rd && reg_addr == ADCM_OFS_MUTE |=>
		reg_rdata[7:6] == 2'h0) else $error("rd mute");
	a_rdata_hold:
	assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata");
	a_out_hold:
	assert property (!sample_en |=> $stable(sample_out)) else $error("out");
endmodule
bind adcm_ctrl adcm_ctrl_props u_props (.mclk, .rst_b, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .single_ended_select,
	.input_invert_select, .sample_en, .sample_out);
`default_nettype wire

// file: tb/adc_input_mute_config_test.sv
// Self-checking bench for adcm_ctrl: registers and soft mute.
// Drives every port itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
module adc_input_mute_config_test
	import adcm_pkg::*;
;
	logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sample_en = 0;
	logic attenuation_ramp_speed = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [47:0] atten_level = 0;
	logic [5:0] single_ended_select, input_invert_select;
	logic [143:0] sample_in = 0, sample_out; // Six packed channels
	int errors = 0, comparisons = 0, seed = 32'hed500572, m[3];
	longint p;
	always #4 mclk = ~mclk;
	adcm_ctrl dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .attenuation_ramp_speed, .atten_level,
		.single_ended_select, .input_invert_select, .sample_en,
		.sample_in, .sample_out);
	// Magnitude of one signed output sample
	function automatic longint mag(input logic [23:0] v);
		longint s;
		s = $signed(v);
		return s < 0 ? -s : s;
	endfunction
	task chk(input logic [23:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One-cycle write; model keeps live bits only
	task wr(input logic [7:0] a, d);
		@(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge mclk) reg_wr = 0;
		if (a inside {[8'h53:8'h55]}) m[a - 8'h53] = d & 8'h3f;
	endtask
	task rd(input logic [7:0] a);
		@(negedge mclk) {reg_addr, reg_rd} = {a, 1'b1};
		@(negedge mclk) reg_rd = 0;
		chk(reg_rdata, a inside {[8'h53:8'h55]} ? m[a - 8'h53] : 0);
	endtask
	// Run n frames; a channel heading for silence may only fall and one
	// heading for its level may only rise; then compare all six channels
	task frames(input int n, input logic [5:0] on);
		longint prev[6];
		longint now;
		for (int c = 0; c < 6; c++) begin
			prev[c] = mag(sample_out[c*24+:24]);
		end
		repeat (n) begin
			@(negedge mclk) sample_en = 1;
			@(negedge mclk) sample_en = 0;
			for (int c = 0; c < 6; c++) begin
				now = mag(sample_out[c*24+:24]);
				chk(on[c] ? now >= prev[c] : now <= prev[c], 24'h1);
				prev[c] = now;
			end
		end
		for (int c = 0; c < 6; c++) begin
			p = $signed(sample_in[c*24+:24])
				* $signed({1'b0, atten_level[c*8+:8]});
			chk(sample_out[c*24+:24], on[c] ? p >>> 8 : 0);
		end
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		rst_b = 1;
		foreach (m[i]) rd(8'h53 + 8'(i));
		rd(8'h56);
		repeat (30) begin
			wr(8'h52 + 8'($unsigned($random(seed)) % 5), 8'($random(seed)));
			rd(reg_addr);
			chk(single_ended_select, m[0]);
			chk(input_invert_select, m[1]);
		end
		// Random samples and levels, cut to the port widths
		sample_in = 144'({$random(seed), $random(seed), $random(seed),
			$random(seed), $random(seed)});
		atten_level = 48'({$random(seed), $random(seed)});
		wr(8'h55, 8'h00);
		frames(70, 6'h3f);
		// Even channels mute, odd ones keep their level
		wr(8'h55, 8'hd5);
		rd(8'h55);
		frames(70, 6'h2a);
		// Slow speed: swap which channels are muted
		attenuation_ramp_speed = 1;
		wr(8'h55, 8'h2a);
		frames(260, 6'h15);
		// Mid-run reset brings back zeros and settled ramps
		@(negedge mclk) rst_b = 0;
		repeat (3) @(negedge mclk);
		rst_b = 1;
		m = '{default: 0};
		foreach (m[i]) rd(8'h53 + 8'(i));
		chk(sample_out[23:0], 24'h0);
		frames(4, 6'h3f);
		close_out;
	end
	// Hang guard: run is about 1000 cycles, this allows 2500
	initial begin
		#20000;
		errors++;
		close_out;
	end
endmodule
`default_nettype wire
